// ===== src/ats_consts.svh
// constants for the acquisition trigger select block
`ifndef ATS_CONSTS_SVH
`define ATS_CONSTS_SVH
`define ATS_SRC_W 2
`define ATS_SRC_SW 2'h0
`define ATS_SRC_DIN 2'h1
`define ATS_SRC_PULSE 2'h2
`define ATS_SRC_POS 2'h3
`define ATS_CNT_W 32
`define ATS_POS_W 32
`define ATS_SCAN_W 24
`define ATS_SCAN_RST 24'h000000
`endif

// ===== src/ats_pkg.sv
// types for the acquisition trigger select block
`include "ats_consts.svh"
package ats_pkg;
  typedef enum logic [1:0] {
    ATS_IDLE = 2'b00,
    ATS_ACQ = 2'b01
  } ats_state_type;
  typedef struct packed {
    logic [`ATS_SRC_W-1:0] src;
    logic din_falling;
    logic retrig_en;
    logic [`ATS_SCAN_W-1:0] post_trigger_scan_count;
    logic [`ATS_CNT_W-1:0] pulse_threshold;
    logic [`ATS_POS_W-1:0] pos_compare;
  } ats_cfg_type;
endpackage : ats_pkg

// ===== src/ats_quad_decoder.sv
// x4 quadrature decoder with position comparator
`include "ats_consts.svh"
module ats_quad_decoder (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic resetn_i,
  // encoder phases, already synchronised
  input wire logic phase_a_i,
  input wire logic phase_b_i,
  input wire logic pos_clear_i,
  input wire logic [`ATS_POS_W-1:0] pos_compare_i,
  // results
  output logic [`ATS_POS_W-1:0] position_o,
  output logic pos_match_o
);
  logic a_r, b_r, a_nxt, b_nxt;
  logic [`ATS_POS_W-1:0] pos_r, pos_nxt;
  logic match_r, match_nxt;

  always_comb begin
    a_nxt = phase_a_i;
    b_nxt = phase_b_i;
    pos_nxt = pos_r;
    // every edge on either phase counts, direction from phase relation [R11]
    if (pos_clear_i) begin
      pos_nxt = '0;
    end else if ((a_r ^ phase_a_i) || (b_r ^ phase_b_i)) begin
      if ((a_r ^ phase_b_i) && !(b_r ^ phase_a_i)) begin
        pos_nxt = pos_r + `ATS_POS_W'(1);
      end else if ((b_r ^ phase_a_i) && !(a_r ^ phase_b_i)) begin
        pos_nxt = pos_r - `ATS_POS_W'(1);
      end
    end
    // one pulse each time the count arrives on the compare value [R10]
    match_nxt = (pos_nxt == pos_compare_i) && (pos_nxt != pos_r);
  end

  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      a_r <= 1'b0;
      b_r <= 1'b0;
      pos_r <= '0;
      match_r <= 1'b0;
    end else begin
      a_r <= a_nxt;
      b_r <= b_nxt;
      pos_r <= pos_nxt;
      match_r <= match_nxt;
    end
  end

  assign position_o = pos_r;
  assign pos_match_o = match_r;
endmodule : ats_quad_decoder

// ===== src/ats_trigger_select.sv
// acquisition trigger select: source choice, comparators and post-trigger control
// ****************************************************************
// Overview of operation
// R1 - four trigger sources exist: software, digital input 0 edge, pulse and position compare.
// R2 - only the one selected source can start an acquisition.
// R3 - acquisition starts the cycle after the trigger and collects the programmed scan count.
// R4 - with software selected, the start command triggers at once.
// R5 - with digital selected, the chosen rising or falling edge of input 0 triggers.
// R6 - a new digital edge is taken only after the scans finish, and with re-trigger off only after a stop or start command rearms.
// R7 - the pulse comparator fires once the generated pulse count reaches the threshold.
// R8 - used as a delay, acquisition starts right when count times period has elapsed.
// R9 - a restarted pulse generator may re-trigger after the scans finish when re-trigger is on.
// R10 - the position comparator fires each time the decoder count equals the compare value.
// R11 - the decoder counts every edge of either phase for four-times resolution.
// R12 - repeated position matches re-trigger only after the scans finish, with re-trigger on or after a stop or start command rearms.
// R13 - a trigger during an acquisition is dropped, never queued.
// ****************************************************************
`include "ats_consts.svh"
module ats_trigger_select
  import ats_pkg::*;
(
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic resetn_i,
  // host configuration and commands
  input wire ats_pkg::ats_cfg_type cfg_i,
  input wire logic sw_start_i,
  input wire logic acq_stop_i,
  input wire logic pos_clear_i,
  // pins from outside the clock domain
  input wire logic din0_i,
  input wire logic enc_a_i,
  input wire logic enc_b_i,
  // pulse-command generator events
  input wire logic pulse_gen_start_i,
  input wire logic pulse_out_i,
  // acquisition sequencer
  input wire logic scan_done_i,
  output logic acq_start_o,
  output logic acq_busy_o,
  output logic [`ATS_SCAN_W-1:0] scans_left_o,
  // status
  output logic [`ATS_CNT_W-1:0] pulse_count_o,
  output logic [`ATS_POS_W-1:0] position_o,
  output logic trig_seen_o
);
  import ats_pkg::*;

  // ****************************************************************
  // pin synchronisers
  // ****************************************************************
  logic [2:0] pin_s1_r, pin_s2_r;
  logic [2:0] pin_s1_nxt;
  logic [2:0] fill_r, fill_nxt;
  logic pins_ok;
  assign pin_s1_nxt = {enc_b_i, enc_a_i, din0_i};
  // edges ignored until real pin levels reach the last stage,
  // else a pin idling high looks like an edge right after reset
  assign fill_nxt = {fill_r[1:0], 1'b1};
  assign pins_ok = fill_r[2];

  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pin_s1_r <= 3'h0;
      pin_s2_r <= 3'h0;
      fill_r <= 3'h0;
    end else begin
      pin_s1_r <= pin_s1_nxt;
      pin_s2_r <= pin_s1_r;
      fill_r <= fill_nxt;
    end
  end

  // ****************************************************************
  // edge detect on digital input 0
  // ****************************************************************
  logic din_d_r, din_d_nxt;
  logic din_rise, din_fall;
  logic din_edge;
  assign din_d_nxt = pin_s2_r[0];
  assign din_rise = ~din_d_r & pin_s2_r[0];
  assign din_fall = din_d_r & ~pin_s2_r[0];
  // polarity picked by software [R5]
  assign din_edge = pins_ok & (cfg_i.din_falling ? din_fall : din_rise);

  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      din_d_r <= 1'b0;
    end else begin
      din_d_r <= din_d_nxt;
    end
  end

  // ****************************************************************
  // pulse comparator
  // ****************************************************************
  logic [`ATS_CNT_W-1:0] pcount_r, pcount_nxt;
  logic pfired_r, pfired_nxt;
  logic pulse_hit;

  always_comb begin
    pcount_nxt = pcount_r;
    pfired_nxt = pfired_r;
    pulse_hit = 1'b0;
    // generator restart rearms the comparator, no acquisition stop needed [R9]
    if (pulse_gen_start_i) begin
      pcount_nxt = '0;
      pfired_nxt = 1'b0;
    end else if (pulse_out_i) begin
      pcount_nxt = pcount_r + `ATS_CNT_W'(1);
      // fires on the pulse that completes count x period, no extra delay [R7] [R8]
      if (!pfired_r && pcount_nxt >= cfg_i.pulse_threshold) begin
        pulse_hit = 1'b1;
        pfired_nxt = 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pcount_r <= '0;
      pfired_r <= 1'b0;
    end else begin
      pcount_r <= pcount_nxt;
      pfired_r <= pfired_nxt;
    end
  end

  // ****************************************************************
  // position comparator
  // ****************************************************************
  logic pos_hit;
  logic dec_clear;
  // decoder takes the settled phase levels before counting starts
  assign dec_clear = pos_clear_i | ~pins_ok;

  ats_quad_decoder u_decoder (
    .sys_clk_i(sys_clk_i),
    .resetn_i(resetn_i),
    .phase_a_i(pin_s2_r[1]),
    .phase_b_i(pin_s2_r[2]),
    .pos_clear_i(dec_clear),
    .pos_compare_i(cfg_i.pos_compare),
    .position_o(position_o),
    .pos_match_o(pos_hit)
  );

  // ****************************************************************
  // source select and acquisition control
  // ****************************************************************
  ats_state_type state_r, state_nxt;
  logic [`ATS_SCAN_W-1:0] left_r, left_nxt;
  logic armed_r, armed_nxt;
  logic start_r, start_nxt;
  logic seen_r, seen_nxt;
  logic trig;

  // one mux, so a source that is not selected can never start [R1] [R2]
  always_comb begin
    case (cfg_i.src)
      `ATS_SRC_SW: trig = sw_start_i; // [R4]
      `ATS_SRC_DIN: trig = din_edge; // [R5]
      `ATS_SRC_PULSE: trig = pulse_hit; // [R7]
      default: trig = pos_hit; // [R10]
    endcase
  end

  always_comb begin
    state_nxt = state_r;
    left_nxt = left_r;
    armed_nxt = armed_r;
    start_nxt = 1'b0;
    seen_nxt = seen_r | trig;
    case (state_r)
      ATS_IDLE: begin
        // without re-trigger only the first trigger after arming counts [R6] [R12]
        // the start command is itself a host request, so it needs no arming [R4]
        if (trig && (armed_r || cfg_i.src == `ATS_SRC_SW) &&
            cfg_i.post_trigger_scan_count != `ATS_SCAN_RST) begin
          state_nxt = ATS_ACQ;
          left_nxt = cfg_i.post_trigger_scan_count;
          start_nxt = 1'b1; // [R3]
          armed_nxt = cfg_i.retrig_en;
        end
      end
      ATS_ACQ: begin
        // triggers here fall through unused, nothing is queued [R13] [R9]
        if (acq_stop_i) begin
          state_nxt = ATS_IDLE;
          left_nxt = `ATS_SCAN_RST;
        end else if (scan_done_i) begin
          left_nxt = left_r - `ATS_SCAN_W'(1);
          if (left_r == `ATS_SCAN_W'(1)) begin
            state_nxt = ATS_IDLE;
          end
        end
      end
      default: state_nxt = ATS_IDLE;
    endcase
    // stop, or software start while idle, rearms a one-shot run
    if (acq_stop_i || (sw_start_i && state_r == ATS_IDLE)) begin
      armed_nxt = 1'b1;
    end
  end

  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_r <= ATS_IDLE;
      left_r <= `ATS_SCAN_RST;
      armed_r <= 1'b1;
      start_r <= 1'b0;
      seen_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      left_r <= left_nxt;
      armed_r <= armed_nxt;
      start_r <= start_nxt;
      seen_r <= seen_nxt;
    end
  end

  assign acq_start_o = start_r;
  assign acq_busy_o = (state_r == ATS_ACQ);
  assign scans_left_o = left_r;
  assign pulse_count_o = pcount_r;
  assign trig_seen_o = seen_r;
endmodule : ats_trigger_select

// ===== verification/ats_monitor.sv
// assertion checker on the trigger select ports
`include "ats_consts.svh"
module ats_monitor
  import ats_pkg::*;
(
  // watched ports
  input wire logic sys_clk_i,
  input wire logic resetn_i,
  input wire ats_pkg::ats_cfg_type cfg_i,
  input wire logic sw_start_i,
  input wire logic acq_stop_i,
  input wire logic scan_done_i,
  input wire logic acq_start_o,
  input wire logic acq_busy_o,
  input wire logic [`ATS_SCAN_W-1:0] scans_left_o
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!resetn_i);
  AST_WIDTH: assert property (acq_start_o |=> !acq_start_o)
    else $error("start too wide");
  AST_BUSY: assert property (acq_start_o |-> acq_busy_o)
    else $error("start without busy");
  AST_FRESH: assert property (acq_start_o |-> !$past(acq_busy_o))
    else $error("start while busy");
  AST_SOFT: assert property (cfg_i.src == `ATS_SRC_SW && sw_start_i && !acq_stop_i
    && !acq_busy_o && cfg_i.post_trigger_scan_count != 24'h0 |=> acq_start_o)
    else $error("soft start lost");
  AST_LOAD: assert property (acq_start_o |-> scans_left_o == cfg_i.post_trigger_scan_count)
    else $error("bad scan load");
  AST_DEC: assert property (acq_busy_o && scan_done_i && scans_left_o > 24'h1 && !acq_stop_i
    |=> scans_left_o == $past(scans_left_o) - 24'h1)
    else $error("scan count off");
  AST_END: assert property (acq_busy_o && scan_done_i && scans_left_o == 24'h1 && !acq_stop_i
    |=> !acq_busy_o)
    else $error("busy overruns");
  AST_ZERO: assert property (cfg_i.post_trigger_scan_count == 24'h0 |=> !acq_start_o)
    else $error("start on zero count");
endmodule : ats_monitor
bind ats_trigger_select ats_monitor i_ats_monitor (.sys_clk_i, .resetn_i, .cfg_i, .sw_start_i,
  .acq_stop_i, .scan_done_i, .acq_start_o, .acq_busy_o, .scans_left_o);

// ===== verification/ats_seq_model.sv
// acquisition sequencer model: one scan done per gap_i+1 busy cycles
module ats_seq_model (
  // sequencer side
  input wire logic sys_clk_i,
  input wire logic busy_i,
  input wire logic [3:0] gap_i,
  output logic done_o
);
  timeunit 1ns;
  timeprecision 100ps;
  int cnt = 0;
  initial done_o = 1'b0;
  // paced off the sampling edge so the block never sees a race
  always @(negedge sys_clk_i) begin
    cnt = busy_i ? cnt + 1 : 0;
    done_o <= cnt > gap_i;
    if (cnt > gap_i) cnt = 0;
  end
endmodule : ats_seq_model

// ===== verification/ats_trigger_select_bench.sv
// self-checking bench for the acquisition trigger select block
`include "ats_consts.svh"
module ats_trigger_select_bench;
  timeunit 1ns;
  timeprecision 100ps;
  import ats_pkg::*;
  logic clk = '0, rstn = '0, sw = '0, stp = '0, din = '0, pgs = '0, pout = '0, sd, st, busy;
  logic clr = '0, ea = '0, eb = '0, seen;
  logic [`ATS_SCAN_W-1:0] left;
  logic [31:0] pcnt, pos;
  logic [3:0] gap = '0;
  ats_cfg_type cfg = '0;
  integer seed = 32'he1d0;
  int n_mismatch = 0, checks_done = 0, n = 1, done_cnt = 0, qpos = 0;
  initial forever #12.5 clk = ~clk;
  ats_trigger_select i_ats_trigger_select (.sys_clk_i(clk), .resetn_i(rstn), .cfg_i(cfg),
    .sw_start_i(sw), .acq_stop_i(stp), .pos_clear_i(clr), .din0_i(din), .enc_a_i(ea),
    .enc_b_i(eb), .pulse_gen_start_i(pgs), .pulse_out_i(pout), .scan_done_i(sd),
    .acq_start_o(st), .acq_busy_o(busy), .scans_left_o(left), .pulse_count_o(pcnt),
    .position_o(pos), .trig_seen_o(seen));
  ats_seq_model i_ats_seq_model (.sys_clk_i(clk), .busy_i(busy), .gap_i(gap), .done_o(sd));
  // model count of scans finished, ignoring strays after the last
  always @(posedge clk) if (sd === 1'b1 && busy === 1'b1 && left != 0) done_cnt++;
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic tick(input int k = 1);
    repeat (k) @(negedge clk);
  endtask : tick
  task automatic pulse(ref logic s);
    s = 1'b1;
    tick();
    s = 1'b0;
  endtask : pulse
  // one quadrature step, phases follow the gray code of the model position
  task automatic step(input int d);
    qpos += d;
    ea = qpos[1];
    eb = qpos[1] ^ qpos[0];
    tick(2);
  endtask : step
  // poke throws a soft start into the busy window
  task automatic acq(input logic exp, input logic poke);
    for (int k = 0; k < 12 && st !== 1'b1; k++) tick();
    chk(st === 1'b1, exp);
    if (st === 1'b1) begin
      done_cnt = 0;
      chk(left, n);
      if (poke) pulse(sw);
      for (int k = 0; k < 400 && busy === 1'b1; k++) tick();
      chk(done_cnt, n);
    end
  endtask : acq
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : report_and_stop
  initial begin
    #100us n_mismatch++;
    report_and_stop();
  end
  // ****
  // tests
  // ****
  initial begin
    tick(3);
    rstn = 1'b1;
    tick();
    chk(seen, 32'h0);
    n = 1 + $unsigned($random(seed)) % 4;
    cfg.post_trigger_scan_count = n[`ATS_SCAN_W-1:0];
    gap = 4'h8;
    pulse(sw);
    acq(1'b1, 1'b1);
    acq(1'b0, 1'b0);
    pulse(sw);
    acq(1'b1, 1'b0);
    chk(seen, 32'h1);
    $display("software test done");
    cfg.src = `ATS_SRC_DIN;
    for (int p = 0; p < 2; p++) begin
      gap = 4'($random(seed));
      cfg.din_falling = p[0];
      pulse(stp);
      tick(4);
      din = ~din;
      acq(1'b1, 1'b0);
      din = ~din;
      tick(4);
      din = ~din;
      acq(1'b0, 1'b0);
    end
    $display("digital input test done");
    cfg.src = `ATS_SRC_PULSE;
    cfg.retrig_en = 1'b1;
    cfg.pulse_threshold = 32'h3;
    pulse(stp);
    repeat (2) begin
      pulse(pgs);
      repeat (2) begin
        pulse(pout);
        tick();
      end
      acq(1'b0, 1'b0);
      chk(pcnt, 32'h2);
      pulse(pout);
      acq(1'b1, 1'b0);
    end
    pulse(sw);
    din = ~din;
    acq(1'b0, 1'b0);
    $display("pulse comparator test done");
    cfg.src = `ATS_SRC_POS;
    cfg.pos_compare = 32'h3;
    repeat (3) step(1);
    acq(1'b1, 1'b0);
    step(-1);
    tick(2);
    chk(pos, qpos);
    step(1);
    acq(1'b1, 1'b0);
    cfg.retrig_en = 1'b0;
    for (int r = 0; r < 2; r++) begin
      step(-1);
      step(1);
      acq(r == 0, 1'b0);
    end
    chk(pos, qpos);
    pulse(clr);
    chk(pos, 32'h0);
    $display("position comparator test done");
    report_and_stop();
  end
endmodule : ats_trigger_select_bench
